// [rtl/xic_pkg.sv]
package xic_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] XIC_ADDR_EXT_FLAGS  = 8'h91;
    localparam logic [7:0] XIC_ADDR_BASIC_PRIO = 8'hB8;
    localparam logic [7:0] XIC_ADDR_EXT_EN     = 8'hE8;
    localparam logic [7:0] XIC_ADDR_EXT_PRIO   = 8'hF8;
    localparam logic [7:0] XIC_ADDR_CTRL       = 8'hC0;
    localparam logic [7:0] XIC_ADDR_EVT_STAT   = 8'hC1;
    localparam logic [7:0] XIC_ADDR_EVT_MASK   = 8'hC2;
    localparam logic [7:0] XIC_ADDR_DISPATCH   = 8'hC3;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] XIC_RST_EXT_FLAGS   = 8'h00;
    localparam logic [7:0] XIC_RST_BASIC_PRIO  = 8'h00;
    localparam logic [7:0] XIC_RST_EXT_EN      = 8'h00;
    localparam logic [7:0] XIC_RST_EXT_PRIO    = 8'h00;
    localparam logic [7:0] XIC_RST_CTRL        = 8'h00;
    localparam logic [7:0] XIC_RST_EVT_STAT    = 8'h00;
    localparam logic [7:0] XIC_RST_EVT_MASK    = 8'h00;

    // ------------------------------------------------------------------
    // Field positions (extended enable / priority / flag share order)
    // ------------------------------------------------------------------
    localparam int XIC_BIT_SLOW_TIMER   = 7;
    localparam int XIC_BIT_SERIAL_SLAVE = 6;
    localparam int XIC_BIT_PWM_CAPTURE  = 5;
    localparam int XIC_BIT_WATCHDOG     = 4;
    localparam int XIC_BIT_RESERVED_SRC = 3;
    localparam int XIC_BIT_TOUCH        = 2;
    localparam int XIC_BIT_LOW_VOLTAGE  = 1;
    localparam int XIC_BIT_TWO_WIRE_MST = 0;
    localparam int XIC_BIT_BASIC_UNUSED = 7;
    localparam int XIC_BIT_CTRL_MASTER  = 0;

    // Basic priority register fields
    localparam int XIC_BIT_UART_TWO     = 6;
    localparam int XIC_BIT_TIMER_TWO    = 5;
    localparam int XIC_BIT_UART_ZERO    = 4;
    localparam int XIC_BIT_TIMER_ONE    = 3;
    localparam int XIC_BIT_PIN_ONE      = 2;
    localparam int XIC_BIT_TIMER_ZERO   = 1;
    localparam int XIC_BIT_PIN_ZERO     = 0;

    // Dispatch register fields
    localparam int XIC_BIT_DSP_VALID    = 7;
    localparam int XIC_BIT_DSP_HIGH     = 6;

    // Source counts and natural order
    localparam int XIC_NUM_BASIC        = 7;
    localparam int XIC_NUM_EXT          = 8;
    localparam int XIC_NUM_SRC          = 15;
    localparam int XIC_EXT_BASE_INDEX   = 7;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } xic_bus_req_t;

    typedef struct packed {
        logic       valid;
        logic       high;
        logic [3:0] index;
    } xic_dispatch_t;

endpackage

// [rtl/xic_ctrl.sv]
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
module xic_ctrl
(
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    input  wire xic_pkg::xic_bus_req_t  bus_req,
    output logic [7:0]                  bus_rdata,
    input  wire logic [6:0]             basic_src_req,
    input  wire logic [7:0]             group_req,
    input  wire logic                   two_wire_master_event,
    output xic_pkg::xic_dispatch_t      dispatch,
    output logic                        irq
);
    import xic_pkg::*;

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    logic       rst_meta_r;
    logic       rst_sync_r;
    logic       rst_b_int;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    assign rst_b_int = rst_sync_r;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]            ext_en_r;
    logic [7:0]            ext_prio_r;
    logic [7:0]            basic_prio_r;
    logic [7:0]            ctrl_r;
    logic [7:0]            evt_stat_r;
    logic [7:0]            evt_mask_r;
    logic                  two_wire_master_flag_r;
    logic [7:0]            ext_line_prev_r;
    logic [7:0]            rdata_r;
    xic_dispatch_t         dispatch_r;

    logic                  wr_ext_en;
    logic                  wr_ext_prio;
    logic                  wr_basic_prio;
    logic                  wr_ext_flags;
    logic                  wr_ctrl;
    logic                  wr_evt_stat;
    logic                  wr_evt_mask;

    logic [7:0]            ext_line;
    logic [7:0]            ext_flags_view;
    logic [7:0]            ext_req;
    logic [XIC_NUM_SRC-1:0] src_req;
    logic [XIC_NUM_SRC-1:0] src_prio;
    logic [7:0]            evt_set;
    logic                  master_irq_enable;
    xic_dispatch_t         dispatch_nxt;
    logic [7:0]            rdata_nxt;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    assign wr_ext_en     = bus_req.wr && (bus_req.addr == XIC_ADDR_EXT_EN);
    assign wr_ext_prio   = bus_req.wr && (bus_req.addr == XIC_ADDR_EXT_PRIO);
    assign wr_basic_prio = bus_req.wr &&
                           (bus_req.addr == XIC_ADDR_BASIC_PRIO);
    assign wr_ext_flags  = bus_req.wr &&
                           (bus_req.addr == XIC_ADDR_EXT_FLAGS);
    assign wr_ctrl       = bus_req.wr && (bus_req.addr == XIC_ADDR_CTRL);
    assign wr_evt_stat   = bus_req.wr && (bus_req.addr == XIC_ADDR_EVT_STAT);
    assign wr_evt_mask   = bus_req.wr && (bus_req.addr == XIC_ADDR_EVT_MASK);

    // ------------------------------------------------------------------
    // Enable register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            ext_en_r <= XIC_RST_EXT_EN;
        end else if (wr_ext_en) begin
            ext_en_r <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Priority registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            ext_prio_r <= XIC_RST_EXT_PRIO;
        end else if (wr_ext_prio) begin
            ext_prio_r <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            basic_prio_r <= XIC_RST_BASIC_PRIO;
        end else if (wr_basic_prio) begin
            // Unused top bit stays zero
            basic_prio_r <= {1'b0, bus_req.wdata[6:0]};
        end
    end

    // ------------------------------------------------------------------
    // Control register: master interrupt enable
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            ctrl_r <= XIC_RST_CTRL;
        end else if (wr_ctrl) begin
            ctrl_r <= {7'h00, bus_req.wdata[XIC_BIT_CTRL_MASTER]};
        end
    end

    assign master_irq_enable = ctrl_r[XIC_BIT_CTRL_MASTER];

    // ------------------------------------------------------------------
    // Two-wire master flag
    // ------------------------------------------------------------------
    // Only a written zero clears; a new event in the same cycle wins.
    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            two_wire_master_flag_r <= XIC_RST_EXT_FLAGS[0];
        end else if (two_wire_master_event) begin
            two_wire_master_flag_r <= 1'b1;
        end else if (wr_ext_flags &&
                     !bus_req.wdata[XIC_BIT_TWO_WIRE_MST]) begin
            two_wire_master_flag_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Flag view and requests
    // ------------------------------------------------------------------
    // Mirrored bits are wires from the peripherals; writes do not reach
    // them and the watchdog position reads as zero.
    always_comb begin
        ext_line                       = group_req;
        ext_line[XIC_BIT_TWO_WIRE_MST] = two_wire_master_flag_r;
    end

    // ------------------------------------------------------------------
    // Named flag bits
    // ------------------------------------------------------------------
    logic                  slow_timer_group_flag;
    logic                  serial_slave_group_flag;
    logic                  pwm_capture_group_flag;
    logic                  reserved_source_flag;
    logic                  touch_group_flag;
    logic                  low_voltage_flag;
    logic                  two_wire_master_flag;

    assign slow_timer_group_flag   = ext_line[XIC_BIT_SLOW_TIMER];
    assign serial_slave_group_flag = ext_line[XIC_BIT_SERIAL_SLAVE];
    assign pwm_capture_group_flag  = ext_line[XIC_BIT_PWM_CAPTURE];
    assign reserved_source_flag    = ext_line[XIC_BIT_RESERVED_SRC];
    assign touch_group_flag        = ext_line[XIC_BIT_TOUCH];
    assign low_voltage_flag        = ext_line[XIC_BIT_LOW_VOLTAGE];
    assign two_wire_master_flag    = two_wire_master_flag_r;

    // Watchdog position reads zero: its flag lives in the watchdog
    assign ext_flags_view = {slow_timer_group_flag, serial_slave_group_flag,
                             pwm_capture_group_flag, 1'b0,
                             reserved_source_flag, touch_group_flag,
                             low_voltage_flag,
                             two_wire_master_flag};

    // ------------------------------------------------------------------
    // Named enable bits
    // ------------------------------------------------------------------
    logic                  slow_timer_group_en;
    logic                  serial_slave_group_en;
    logic                  pwm_capture_group_en;
    logic                  watchdog_irq_en;
    logic                  reserved_source_en;
    logic                  touch_group_en;
    logic                  low_voltage_en;
    logic                  two_wire_master_en;
    logic [7:0]            ext_gate;

    assign slow_timer_group_en   = ext_en_r[XIC_BIT_SLOW_TIMER];
    assign serial_slave_group_en = ext_en_r[XIC_BIT_SERIAL_SLAVE];
    assign pwm_capture_group_en  = ext_en_r[XIC_BIT_PWM_CAPTURE];
    assign watchdog_irq_en       = ext_en_r[XIC_BIT_WATCHDOG];
    assign reserved_source_en    = ext_en_r[XIC_BIT_RESERVED_SRC];
    assign touch_group_en        = ext_en_r[XIC_BIT_TOUCH];
    assign low_voltage_en        = ext_en_r[XIC_BIT_LOW_VOLTAGE];
    assign two_wire_master_en    = ext_en_r[XIC_BIT_TWO_WIRE_MST];
    assign ext_gate = {slow_timer_group_en, serial_slave_group_en,
                       pwm_capture_group_en, watchdog_irq_en,
                       reserved_source_en, touch_group_en,
                       low_voltage_en, two_wire_master_en};

    // Per-source gating by enable bit
    genvar gi;
    generate
        for (gi = 0; gi < XIC_NUM_EXT; gi++) begin : g_ext
            // Bits 7..0: timers/buzzer, serial slave, pwm/capture,
            // watchdog, reserved, touch, low voltage, two-wire master
            assign ext_req[gi] = ext_line[gi] && ext_gate[gi];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Named priority bits
    // ------------------------------------------------------------------
    logic                  slow_timer_group_prio;
    logic                  serial_slave_group_prio;
    logic                  pwm_capture_group_prio;
    logic                  watchdog_irq_prio;
    logic                  reserved_source_prio;
    logic                  touch_group_prio;
    logic                  low_voltage_prio;
    logic                  two_wire_master_prio;
    logic                  uart_two_prio;
    logic                  timer_two_prio;
    logic                  uart_zero_prio;
    logic                  timer_one_prio;
    logic                  pin_group_one_prio;
    logic                  timer_zero_prio;
    logic                  pin_group_zero_prio;

    assign slow_timer_group_prio   = ext_prio_r[XIC_BIT_SLOW_TIMER];
    assign serial_slave_group_prio = ext_prio_r[XIC_BIT_SERIAL_SLAVE];
    assign pwm_capture_group_prio  = ext_prio_r[XIC_BIT_PWM_CAPTURE];
    assign watchdog_irq_prio       = ext_prio_r[XIC_BIT_WATCHDOG];
    assign reserved_source_prio    = ext_prio_r[XIC_BIT_RESERVED_SRC];
    assign touch_group_prio        = ext_prio_r[XIC_BIT_TOUCH];
    assign low_voltage_prio        = ext_prio_r[XIC_BIT_LOW_VOLTAGE];
    assign two_wire_master_prio    = ext_prio_r[XIC_BIT_TWO_WIRE_MST];
    assign uart_two_prio           = basic_prio_r[XIC_BIT_UART_TWO];
    assign timer_two_prio          = basic_prio_r[XIC_BIT_TIMER_TWO];
    assign uart_zero_prio          = basic_prio_r[XIC_BIT_UART_ZERO];
    assign timer_one_prio          = basic_prio_r[XIC_BIT_TIMER_ONE];
    assign pin_group_one_prio      = basic_prio_r[XIC_BIT_PIN_ONE];
    assign timer_zero_prio         = basic_prio_r[XIC_BIT_TIMER_ZERO];
    assign pin_group_zero_prio     = basic_prio_r[XIC_BIT_PIN_ZERO];

    // Natural order: basic sources 0..6, then extended bits 0..7
    assign src_req  = {ext_req, basic_src_req};
    assign src_prio = {slow_timer_group_prio, serial_slave_group_prio,
                       pwm_capture_group_prio, watchdog_irq_prio,
                       reserved_source_prio, touch_group_prio,
                       low_voltage_prio, two_wire_master_prio,
                       uart_two_prio, timer_two_prio, uart_zero_prio,
                       timer_one_prio, pin_group_one_prio,
                       timer_zero_prio, pin_group_zero_prio};

    // ------------------------------------------------------------------
    // Dispatcher
    // ------------------------------------------------------------------
    always_comb begin
        dispatch_nxt = '0;
        if (master_irq_enable) begin
            for (int i = XIC_NUM_SRC - 1; i >= 0; i--) begin
                if (src_req[i] && !src_prio[i]) begin
                    dispatch_nxt.valid = 1'b1;
                    dispatch_nxt.high  = 1'b0;
                    dispatch_nxt.index = 4'(i);
                end
            end
            // High level overrides whatever low source was picked
            for (int i = XIC_NUM_SRC - 1; i >= 0; i--) begin
                if (src_req[i] && src_prio[i]) begin
                    dispatch_nxt.valid = 1'b1;
                    dispatch_nxt.high  = 1'b1;
                    dispatch_nxt.index = 4'(i);
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            dispatch_r <= '0;
        end else begin
            dispatch_r <= dispatch_nxt;
        end
    end

    assign dispatch = dispatch_r;

    // ------------------------------------------------------------------
    // Event status, mask and interrupt line
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            ext_line_prev_r <= 8'h00;
        end else begin
            ext_line_prev_r <= ext_line;
        end
    end

    assign evt_set = ext_line & ~ext_line_prev_r;

    // Write one to clear; a new rising edge in the same cycle wins
    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            evt_stat_r <= XIC_RST_EVT_STAT;
        end else if (wr_evt_stat) begin
            evt_stat_r <= (evt_stat_r & ~bus_req.wdata) | evt_set;
        end else begin
            evt_stat_r <= evt_stat_r | evt_set;
        end
    end

    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            evt_mask_r <= XIC_RST_EVT_MASK;
        end else if (wr_evt_mask) begin
            evt_mask_r <= bus_req.wdata;
        end
    end

    assign irq = |(evt_stat_r & evt_mask_r);

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    always_comb begin
        rdata_nxt = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                XIC_ADDR_EXT_EN:     rdata_nxt = ext_en_r;
                XIC_ADDR_EXT_PRIO:   rdata_nxt = ext_prio_r;
                XIC_ADDR_BASIC_PRIO: rdata_nxt = basic_prio_r;
                XIC_ADDR_EXT_FLAGS:  rdata_nxt = ext_flags_view;
                XIC_ADDR_CTRL:       rdata_nxt = ctrl_r;
                XIC_ADDR_EVT_STAT:   rdata_nxt = evt_stat_r;
                XIC_ADDR_EVT_MASK:   rdata_nxt = evt_mask_r;
                XIC_ADDR_DISPATCH: begin
                    rdata_nxt[XIC_BIT_DSP_VALID] = dispatch_r.valid;
                    rdata_nxt[XIC_BIT_DSP_HIGH]  = dispatch_r.high;
                    rdata_nxt[3:0]               = dispatch_r.index;
                end
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk or negedge rst_b_int) begin
        if (!rst_b_int) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign bus_rdata = rdata_r;

endmodule // xic_ctrl

// [bench/xic_ctrl_chk.sv]
`timescale 1ns/1ps
module xic_ctrl_chk
(
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire xic_pkg::xic_bus_req_t bus_req,
    input wire logic [7:0]            bus_rdata,
    input wire logic [6:0]            basic_src_req,
    input wire logic [7:0]            group_req,
    input wire logic                  two_wire_master_event,
    input wire xic_pkg::xic_dispatch_t dispatch,
    input wire logic                  irq
);
    import xic_pkg::*;
    logic       m_en_r;
    logic [7:0] en_r;
    logic [7:0] bprio_r;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // ----
    // Shadow of the software settings
    // ----
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            m_en_r  <= 1'b0;
            en_r    <= 8'h00;
            bprio_r <= 8'h00;
        end else if (bus_req.wr) begin
            if (bus_req.addr == XIC_ADDR_CTRL) m_en_r <= bus_req.wdata[0];
            if (bus_req.addr == XIC_ADDR_EXT_EN) en_r <= bus_req.wdata;
            if (bus_req.addr == XIC_ADDR_BASIC_PRIO) bprio_r <= bus_req.wdata;
        end
    end
    rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
        else $error("read data outside read slot");
    en_readback_a: assert property (
        bus_req.wr && bus_req.addr == XIC_ADDR_EXT_EN ##1
        bus_req.rd && bus_req.addr == XIC_ADDR_EXT_EN
        |=> bus_rdata == $past(bus_req.wdata, 2))
        else $error("enable readback differs");
    flag_mirror_a: assert property (
        bus_req.rd && bus_req.addr == XIC_ADDR_EXT_FLAGS |=>
        bus_rdata[7:5] == $past(group_req[7:5]) && !bus_rdata[4] &&
        bus_rdata[3:1] == $past(group_req[3:1]))
        else $error("flag bits do not follow request lines");
    basic_unused_a: assert property (
        bus_req.rd && bus_req.addr == XIC_ADDR_BASIC_PRIO |=> !bus_rdata[7])
        else $error("unused priority bit reads one");
    master_gate_a: assert property (
        !m_en_r && !$past(m_en_r) |-> !dispatch.valid)
        else $error("dispatch while master enable off");
    high_wins_a: assert property (
        (m_en_r && bprio_r[0] && basic_src_req[0]) [*2] |->
        dispatch.valid && dispatch.high && dispatch.index == 4'h0)
        else $error("high level source lost");
    group_disp_a: assert property (
        (m_en_r && en_r == 8'h02 && basic_src_req == 7'h00 &&
         group_req[1]) [*2] |-> dispatch.valid && dispatch.index == 4'h8)
        else $error("enabled group not dispatched");
    i2cm_flag_a: assert property (
        two_wire_master_event ##1
        (bus_req.rd && bus_req.addr == XIC_ADDR_EXT_FLAGS) |=> bus_rdata[0])
        else $error("master flag not set by event");
    cover property (dispatch.valid && dispatch.high);
    cover property (irq);
    cover property (bus_req.rd && bus_req.addr == XIC_ADDR_EXT_FLAGS);
endmodule // xic_ctrl_chk

bind xic_ctrl xic_ctrl_chk xic_ctrl_chk_inst (.clk(clk), .rst_b(rst_b),
    .bus_req(bus_req), .bus_rdata(bus_rdata), .basic_src_req(basic_src_req),
    .group_req(group_req), .two_wire_master_event(two_wire_master_event),
    .dispatch(dispatch), .irq(irq));

// [bench/xic_src_model.sv]
`timescale 1ns/1ps
module xic_src_model
(
    input  wire logic       clk,
    input  wire logic [7:0] grp_set,
    input  wire logic [6:0] basic_set,
    input  wire logic       fire,
    output logic [7:0]      group_req = 8'h00,
    output logic [6:0]      basic_src_req = 7'h00,
    output logic            two_wire_master_event = 1'b0
);
    // Pending flags are dropped inside each source, not through the block
    always @(posedge clk) begin
        group_req             <= grp_set;
        basic_src_req         <= basic_set;
        two_wire_master_event <= fire;
    end
endmodule // xic_src_model

// [bench/xic_ctrl_bench.sv]
`timescale 1ns/1ps
module xic_ctrl_bench;
    import xic_pkg::*;
    logic          clk = 1'b0;
    logic          rst_b = 1'b0;
    xic_bus_req_t  bus_req = '0;
    logic [7:0]    bus_rdata;
    logic [7:0]    grp_set = 8'h00;
    logic [6:0]    basic_set = 7'h00;
    logic          fire = 1'b0;
    logic [7:0]    group_req;
    logic [6:0]    basic_src_req;
    logic          two_wire_master_event;
    xic_dispatch_t dispatch;
    logic          irq;
    logic [7:0]    exp_q[$];
    logic          rd_q = 1'b0;
    logic [15:0]   seed = 16'h0B36;
    logic [7:0]    v;
    logic [7:0]    disp_v;
    int            fail_count = 0;
    int            num_checks = 0;
    localparam logic [7:0] ADDRS [9] = '{XIC_ADDR_EXT_FLAGS,
        XIC_ADDR_BASIC_PRIO, XIC_ADDR_EXT_EN, XIC_ADDR_EXT_PRIO, XIC_ADDR_CTRL,
        XIC_ADDR_EVT_STAT, XIC_ADDR_EVT_MASK, XIC_ADDR_DISPATCH, 8'h55};
    always #50 clk = ~clk;
    assign disp_v = {dispatch.valid, dispatch.high, 2'b00, dispatch.index};
    xic_ctrl xic_ctrl_inst (.clk(clk), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .basic_src_req(basic_src_req),
        .group_req(group_req), .two_wire_master_event(two_wire_master_event),
        .dispatch(dispatch), .irq(irq));
    xic_src_model xic_src_model_inst (.clk(clk), .grp_set(grp_set),
        .basic_set(basic_set), .fire(fire), .group_req(group_req),
        .basic_src_req(basic_src_req),
        .two_wire_master_event(two_wire_master_event));
    // ----
    // Bus tasks and comparison
    // ----
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge clk);
    endtask
    task automatic idle(input int n);
        bus_req <= '0;
        repeat (n) @(posedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Read data is valid only in the cycle after the strobe
    always @(posedge clk) begin
        rd_q <= bus_req.rd;
        if (rd_q) begin
            if (exp_q.size() == 0) check("queue", 8'h01, 8'h00);
            else check("bus_rdata", bus_rdata, exp_q.pop_front());
        end
    end
    initial begin
        #500000;
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        idle(4);
        foreach (ADDRS[i]) rd(ADDRS[i], 8'h00);
        repeat (4) begin
            seed = lfsr(seed);
            v = seed[7:0];
            wr(XIC_ADDR_EXT_EN, v);
            rd(XIC_ADDR_EXT_EN, v);
            wr(XIC_ADDR_EXT_PRIO, ~v);
            rd(XIC_ADDR_EXT_PRIO, ~v);
            wr(XIC_ADDR_BASIC_PRIO, v);
            rd(XIC_ADDR_BASIC_PRIO, v & 8'h7F);
        end
        seed = lfsr(seed);
        grp_set <= seed[15:8];
        idle(3);
        wr(XIC_ADDR_EXT_FLAGS, 8'hFF);
        rd(XIC_ADDR_EXT_FLAGS, seed[15:8] & 8'hEE);
        grp_set <= 8'h00;
        fire <= 1'b1;
        idle(1);
        fire <= 1'b0;
        idle(1);
        rd(XIC_ADDR_EXT_FLAGS, 8'h01);
        wr(XIC_ADDR_EXT_FLAGS, 8'h01);
        rd(XIC_ADDR_EXT_FLAGS, 8'h01);
        wr(XIC_ADDR_EXT_FLAGS, 8'h00);
        rd(XIC_ADDR_EXT_FLAGS, 8'h00);
        wr(XIC_ADDR_CTRL, 8'h01);
        for (int i = 0; i < 8; i++) begin
            wr(XIC_ADDR_EXT_EN, 8'h01 << i);
            wr(XIC_ADDR_EXT_PRIO, 8'hAA);
            grp_set <= 8'h01 << i;
            fire <= (i == 0);
            idle(1);
            fire <= 1'b0;
            idle(3);
            v = {1'b1, i[0], 2'b00, 4'(7 + i)};
            check("dispatch", disp_v, v);
            rd(XIC_ADDR_DISPATCH, v);
            wr(XIC_ADDR_EXT_EN, 8'h00);
            idle(2);
            check("dispatch", disp_v, 8'h00);
            rd(XIC_ADDR_DISPATCH, 8'h00);
        end
        wr(XIC_ADDR_EXT_FLAGS, 8'h00);
        grp_set <= 8'h80;
        wr(XIC_ADDR_EXT_EN, 8'h80);
        wr(XIC_ADDR_CTRL, 8'h00);
        idle(3);
        check("dispatch", disp_v, 8'h00);
        rd(XIC_ADDR_DISPATCH, 8'h00);
        wr(XIC_ADDR_CTRL, 8'h01);
        wr(XIC_ADDR_EXT_PRIO, 8'h80);
        wr(XIC_ADDR_BASIC_PRIO, 8'h00);
        basic_set <= 7'h01;
        idle(3);
        check("dispatch", disp_v, 8'hCE);
        rd(XIC_ADDR_DISPATCH, 8'hCE);
        wr(XIC_ADDR_BASIC_PRIO, 8'h01);
        idle(3);
        check("dispatch", disp_v, 8'hC0);
        rd(XIC_ADDR_DISPATCH, 8'hC0);
        grp_set <= 8'h00;
        basic_set <= 7'h00;
        idle(3);
        wr(XIC_ADDR_EVT_STAT, 8'hFF);
        wr(XIC_ADDR_EVT_MASK, 8'h80);
        grp_set <= 8'h80;
        idle(3);
        check("irq", {7'h00, irq}, 8'h01);
        rd(XIC_ADDR_EVT_STAT, 8'h80);
        wr(XIC_ADDR_EVT_MASK, 8'h00);
        idle(1);
        check("irq", {7'h00, irq}, 8'h00);
        rd(XIC_ADDR_EVT_STAT, 8'h80);
        wr(XIC_ADDR_EVT_STAT, 8'h80);
        wr(XIC_ADDR_EVT_MASK, 8'h80);
        rd(XIC_ADDR_EVT_STAT, 8'h00);
        idle(1);
        check("irq", {7'h00, irq}, 8'h00);
        // Reset again mid-run: the enable and both priority settings must read back zero
        rst_b <= 1'b0;
        idle(4);
        rst_b <= 1'b1;
        idle(4);
        check("dispatch", disp_v, 8'h00);
        rd(XIC_ADDR_EXT_EN, 8'h00);
        rd(XIC_ADDR_EXT_PRIO, 8'h00);
        rd(XIC_ADDR_BASIC_PRIO, 8'h00);
        idle(4);
        report_and_stop();
    end
endmodule // xic_ctrl_bench
